// ==== hw/tcmp_pkg.sv ====
// constants, register map and types for the output compare timer
package tcmp_pkg;

  localparam int unsigned CNT_W   = 16;
  localparam int unsigned NUM_CMP = 6;
  localparam int unsigned NUM_IRQ = 4;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL_FIRST  = 8'h00;
  localparam logic [7:0] OFF_CTRL_SECOND = 8'h04;
  localparam logic [7:0] OFF_WAVE_CTRL   = 8'h08;
  localparam logic [7:0] OFF_COUNT       = 8'h0C;
  localparam logic [7:0] OFF_CMP_ZERO    = 8'h10;
  localparam logic [7:0] OFF_CMP_ONE     = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLEAR   = 8'h1C;
  localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h20;
  localparam logic [7:0] OFF_PIN_FUNC    = 8'h24;

  // field positions
  localparam int unsigned BIT_RUN       = 0;
  localparam int unsigned POS_SRC       = 1;
  localparam int unsigned BIT_CLR_SEL   = 2;
  localparam int unsigned POS_LVL_ZERO  = 4;
  localparam int unsigned POS_LVL_ONE   = 6;
  localparam int unsigned BIT_INV_LOW   = 6;
  localparam int unsigned BIT_INV_HIGH  = 7;
  localparam int unsigned BIT_EXT_IRQ   = 0;
  localparam int unsigned IRQ_CMP_ZERO  = 0;
  localparam int unsigned IRQ_CMP_ONE   = 1;
  localparam int unsigned IRQ_OVERFLOW  = 2;
  localparam int unsigned IRQ_EXT_THREE = 3;

  // reset values and count limits
  localparam logic [7:0]       RST_CTRL  = 8'h00;
  localparam logic [7:0]       RST_WAVE  = 8'h00;
  localparam logic [CNT_W-1:0] RST_CMP   = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX   = 16'hFFFF;

  // prescaler taps: divide by eight and thirty-two
  localparam logic [4:0] DIV_EIGHT_MASK = 5'h07;
  localparam logic [4:0] DIV_THIRTY_TWO = 5'h1F;

  // count source select, gray coded
  typedef enum logic [1:0] {
    SRC_DIV_ONE      = 2'b00,
    SRC_DIV_EIGHT    = 2'b01,
    SRC_DIV_THIRTY_TWO = 2'b11,
    SRC_RING_FAST    = 2'b10
  } count_src_t;

  // output level action on a compare match
  typedef enum logic [1:0] {
    LVL_HOLD   = 2'b00,
    LVL_TOGGLE = 2'b01,
    LVL_LOW    = 2'b10,
    LVL_HIGH   = 2'b11
  } level_act_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;

endpackage : tcmp_pkg

// ==== hw/timer_output_compare.sv ====
// output compare timer with an ahb-lite register slave
//
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps

module timer_output_compare
(
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [7:0]                 haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic                       fast_ring_oscillator_clock,
  input  wire logic                       capture_input_pin,
  output logic      [tcmp_pkg::NUM_CMP-1:0] compare_waveform_output,
  output logic                            capture_pin_gpio_in,
  output logic                            irq
);
  import tcmp_pkg::*;

  // software visible state
  logic [7:0]       timer_control_first_q;
  logic [7:0]       timer_control_second_q;
  logic [7:0]       waveform_output_control_q;
  logic [CNT_W-1:0] compare_value_zero_q;
  logic [CNT_W-1:0] compare_value_one_q;
  logic [NUM_IRQ-1:0] irq_status_q;
  logic [NUM_IRQ-1:0] irq_status_d;
  logic [NUM_IRQ-1:0] irq_enable_q;
  logic             pin_func_q;

  // timer core state
  logic [CNT_W-1:0] timer_count_q;
  logic [CNT_W-1:0] cmp_zero_act_q;
  logic [CNT_W-1:0] cmp_one_act_q;
  logic [4:0]       prescale_q;
  logic             wave_level_q;

  // bus data phase state
  logic             wr_pend_q;
  logic [7:0]       wr_addr_q;

  // synchronisers
  logic [1:0]       ring_sync_q;
  logic             ring_prev_q;
  logic [1:0]       pin_sync_q;
  logic             pin_prev_q;

  // decoded controls
  logic             count_run_bit;
  logic             compare_one_clear_select;
  count_src_t       src_sel;
  level_act_t       lvl_zero;
  level_act_t       lvl_one;
  logic             tick;
  logic             match_zero;
  logic             match_one;
  logic             overflow;
  logic             ext_irq_event;
  logic             addr_phase;
  logic [NUM_IRQ-1:0] clr_mask;

  // one register decode, shared by the read path and the write path
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  // next level for a match action
  function automatic logic apply_lvl(input level_act_t act, input logic cur);
    case (act)
      LVL_TOGGLE: apply_lvl = ~cur;
      LVL_LOW:    apply_lvl = 1'b0;
      LVL_HIGH:   apply_lvl = 1'b1;
      default:    apply_lvl = cur;
    endcase
  endfunction : apply_lvl

  assign count_run_bit            = timer_control_first_q[BIT_RUN];
  assign src_sel                  = count_src_t'(timer_control_first_q[POS_SRC +: 2]);
  assign compare_one_clear_select = timer_control_second_q[BIT_CLR_SEL];
  assign lvl_zero                 = level_act_t'(timer_control_second_q[POS_LVL_ZERO +: 2]);
  assign lvl_one                  = level_act_t'(timer_control_second_q[POS_LVL_ONE +: 2]);
  assign addr_phase               = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // two flops before the asynchronous ring clock and pin are looked at;
  // the gpio view is a third flop so the output comes straight from a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ring_sync_q         <= 2'b00;
      ring_prev_q         <= 1'b0;
      pin_sync_q          <= 2'b00;
      pin_prev_q          <= 1'b0;
      capture_pin_gpio_in <= 1'b0;
    end else begin
      ring_sync_q         <= {ring_sync_q[0], fast_ring_oscillator_clock};
      ring_prev_q         <= ring_sync_q[1];
      pin_sync_q          <= {pin_sync_q[0], capture_input_pin};
      pin_prev_q          <= pin_sync_q[1];
      capture_pin_gpio_in <= pin_sync_q[1];
    end
  end

  // free running prescaler; wraps at thirty-two so both taps share it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_q <= 5'h00;
    end else begin
      prescale_q <= prescale_q + 5'h01;
    end
  end

  // count source select; the ring oscillator only counts rising edges
  // and must run well below hclk/2 to be seen at all
  always_comb begin
    case (src_sel)
      SRC_DIV_ONE:        tick = 1'b1;
      SRC_DIV_EIGHT:      tick = ((prescale_q & DIV_EIGHT_MASK) == DIV_EIGHT_MASK);
      SRC_DIV_THIRTY_TWO: tick = (prescale_q == DIV_THIRTY_TWO);
      SRC_RING_FAST:      tick = ring_sync_q[1] & ~ring_prev_q;
      default:            tick = 1'b0;
    endcase
  end

  // matches are judged once per tick so a slow source cannot repeat them
  assign match_zero = count_run_bit & tick & (timer_count_q == cmp_zero_act_q);
  assign match_one  = count_run_bit & tick & (timer_count_q == cmp_one_act_q);
  assign overflow   = count_run_bit & tick & (timer_count_q == CNT_MAX) & ~(compare_one_clear_select & match_one);

  // the pin never latches the count; it only feeds gpio and irq three
  assign ext_irq_event       = pin_func_q & pin_sync_q[1] & ~pin_prev_q;

  // counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_count_q <= CNT_ZERO;
    end else if (!count_run_bit) begin
      timer_count_q <= CNT_ZERO;
    end else if (match_one && compare_one_clear_select) begin
      timer_count_q <= CNT_ZERO;
    end else if (tick) begin
      timer_count_q <= timer_count_q + 16'h0001;
    end
  end

  // active compare values: follow the buffers while stopped,
  // reload at the end of each counting period while running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_zero_act_q <= RST_CMP;
      cmp_one_act_q  <= RST_CMP;
    end else if (!count_run_bit
                 || (!compare_one_clear_select && overflow)
                 || (compare_one_clear_select && match_one)) begin
      cmp_zero_act_q <= compare_value_zero_q;
      cmp_one_act_q  <= compare_value_one_q;
    end
  end

  // shared waveform level; compare one wins when both match together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_level_q <= 1'b0;
    end else if (match_one) begin
      wave_level_q <= apply_lvl(lvl_one, wave_level_q);
    end else if (match_zero) begin
      wave_level_q <= apply_lvl(lvl_zero, wave_level_q);
    end
  end

  // pin outputs: lower three use one inversion bit, upper three the other;
  // a disabled output rests low instead of following the waveform
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_out
      localparam int unsigned INV_BIT = (gi < NUM_CMP / 2) ? BIT_INV_LOW : BIT_INV_HIGH;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          compare_waveform_output[gi] <= 1'b0;
        end else if (waveform_output_control_q[gi]) begin
          compare_waveform_output[gi] <= wave_level_q ^ waveform_output_control_q[INV_BIT];
        end else begin
          compare_waveform_output[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // latch the address phase of a write for use in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase & hwrite;
      wr_addr_q <= haddr;
    end
  end

  // control registers; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_control_first_q     <= RST_CTRL;
      timer_control_second_q    <= RST_CTRL;
      waveform_output_control_q <= RST_WAVE;
      irq_enable_q              <= '0;
      pin_func_q                <= 1'b0;
    end else if (wr_pend_q) begin
      if (hit(wr_addr_q, OFF_CTRL_FIRST)) begin
        timer_control_first_q <= hwdata[7:0];
      end
      if (hit(wr_addr_q, OFF_CTRL_SECOND)) begin
        timer_control_second_q <= hwdata[7:0];
      end
      if (hit(wr_addr_q, OFF_WAVE_CTRL)) begin
        waveform_output_control_q <= hwdata[7:0];
      end
      if (hit(wr_addr_q, OFF_IRQ_ENABLE)) begin
        irq_enable_q <= hwdata[NUM_IRQ-1:0];
      end
      if (hit(wr_addr_q, OFF_PIN_FUNC)) begin
        pin_func_q <= hwdata[BIT_EXT_IRQ];
      end
    end
  end

  // compare buffers take whole words only; the count itself is read only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_value_zero_q <= RST_CMP;
      compare_value_one_q  <= RST_CMP;
    end else if (wr_pend_q) begin
      if (hit(wr_addr_q, OFF_CMP_ZERO)) begin
        compare_value_zero_q <= hwdata[CNT_W-1:0];
      end
      if (hit(wr_addr_q, OFF_CMP_ONE)) begin
        compare_value_one_q <= hwdata[CNT_W-1:0];
      end
    end
  end

  // sticky status: a new event in the clear cycle survives the clear
  assign clr_mask = (wr_pend_q && hit(wr_addr_q, OFF_IRQ_CLEAR)) ? hwdata[NUM_IRQ-1:0] : '0;
  always_comb begin
    irq_status_d                = irq_status_q & ~clr_mask;
    irq_status_d[IRQ_CMP_ZERO]  = irq_status_d[IRQ_CMP_ZERO]  | match_zero;
    irq_status_d[IRQ_CMP_ONE]   = irq_status_d[IRQ_CMP_ONE]   | match_one;
    irq_status_d[IRQ_OVERFLOW]  = irq_status_d[IRQ_OVERFLOW]  | overflow;
    irq_status_d[IRQ_EXT_THREE] = irq_status_d[IRQ_EXT_THREE] | ext_irq_event;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  // level interrupt; one cycle behind the status flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_enable_q);
    end
  end

  // read data is sampled in the address phase so hrdata comes from a flop;
  // unmapped and write-only offsets read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= 32'h0000_0000;
      if (hit(haddr, OFF_CTRL_FIRST)) begin
        hrdata[7:0] <= timer_control_first_q;
      end
      if (hit(haddr, OFF_CTRL_SECOND)) begin
        hrdata[7:0] <= timer_control_second_q;
      end
      if (hit(haddr, OFF_WAVE_CTRL)) begin
        hrdata[7:0] <= waveform_output_control_q;
      end
      if (hit(haddr, OFF_COUNT)) begin
        hrdata[CNT_W-1:0] <= timer_count_q;
      end
      if (hit(haddr, OFF_CMP_ZERO)) begin
        hrdata[CNT_W-1:0] <= compare_value_zero_q;
      end
      if (hit(haddr, OFF_CMP_ONE)) begin
        hrdata[CNT_W-1:0] <= compare_value_one_q;
      end
      if (hit(haddr, OFF_IRQ_STATUS)) begin
        hrdata[NUM_IRQ-1:0] <= irq_status_q;
      end
      if (hit(haddr, OFF_IRQ_ENABLE)) begin
        hrdata[NUM_IRQ-1:0] <= irq_enable_q;
      end
      if (hit(haddr, OFF_PIN_FUNC)) begin
        hrdata[BIT_EXT_IRQ] <= pin_func_q;
      end
    end
  end

  // zero wait state slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : timer_output_compare

// ==== testbench/tcmp_chk.sv ====
// port-level assertion checker for the output compare timer
`timescale 1ns/1ps
module tcmp_chk
  import tcmp_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        capture_input_pin,
  input wire logic [5:0]  compare_waveform_output,
  input wire logic        capture_pin_gpio_in,
  input wire logic        irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic        take;
  logic        wr_q;
  logic [7:0]  a_q;
  logic [5:0]  wave_q;
  logic [15:0] cmp0_q;
  logic        run_q;
  logic [3:0]  en_q;
  logic [2:0]  age_q;

  assign take = hsel & hready & htrans[1];

  // shadow of the registers the assertions depend on, fed from completed writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      a_q    <= 8'h00;
      wave_q <= 6'h00;
      cmp0_q <= 16'hFFFF;
      run_q  <= 1'b0;
      en_q   <= 4'h0;
      age_q  <= 3'h0;
    end else begin
      wr_q  <= take & hwrite;
      a_q   <= haddr;
      age_q <= (age_q == 3'h7) ? age_q : age_q + 3'h1; // synchroniser settles after reset
      if (wr_q && a_q == OFF_WAVE_CTRL) wave_q <= hwdata[5:0];
      if (wr_q && a_q == OFF_CMP_ZERO) cmp0_q <= hwdata[15:0];
      if (wr_q && a_q == OFF_CTRL_FIRST) run_q <= hwdata[0];
      if (wr_q && a_q == OFF_IRQ_ENABLE) en_q <= hwdata[3:0];
    end
  end

  ready_high_a: assert property (hreadyout)
    else $error("hreadyout dropped");
  resp_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  unmapped_zero_a: assert property (take && !hwrite && haddr[7:2] > 6'd9 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  cmp_read_a: assert property (take && !hwrite && !wr_q && haddr == OFF_CMP_ZERO |=> hrdata == {16'h0000, cmp0_q})
    else $error("compare zero readback wrong");
  wave_read_a: assert property (take && !hwrite && !wr_q && haddr == OFF_WAVE_CTRL |=> hrdata[5:0] == wave_q)
    else $error("waveform control readback wrong");
  stop_zero_a: assert property (take && !hwrite && haddr == OFF_COUNT && !run_q && !$past(run_q)
    |=> hrdata == 32'h0000_0000) else $error("stopped count not zero");
  wave_off_a: assert property ((compare_waveform_output & ~wave_q & ~$past(wave_q)) == 6'h00)
    else $error("disabled waveform output driven");
  irq_mask_a: assert property (en_q == 4'h0 && $past(en_q) == 4'h0 |-> !irq)
    else $error("irq high with all sources masked");
  gpio_follow_a: assert property (age_q == 3'h7 && capture_input_pin == $past(capture_input_pin)
    && capture_input_pin == $past(capture_input_pin, 2) && capture_input_pin == $past(capture_input_pin, 3)
    |-> capture_pin_gpio_in == capture_input_pin) else $error("gpio level does not follow pin");
endmodule : tcmp_chk

bind timer_output_compare tcmp_chk u_tcmp_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .capture_input_pin, .compare_waveform_output, .capture_pin_gpio_in, .irq);

// ==== testbench/wave_sink.sv ====
// load on the waveform pins: counts rising edges seen on output zero
`timescale 1ns/1ps
module wave_sink (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [5:0] wave,
  output int unsigned     rises
);
  logic prev_q;

  // edge counter, sampled on the system clock as a slow external load would see it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b0;
      rises  <= 0;
    end else begin
      prev_q <= wave[0];
      if (wave[0] && !prev_q) rises <= rises + 1;
    end
  end
endmodule : wave_sink

// ==== testbench/timer_output_compare_tb.sv ====
// self-checking bench for the output compare timer
`timescale 1ns/1ps
module timer_output_compare_tb;
  import tcmp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ring, cap, gpio, irq;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, v, w;
  logic [5:0]  wave;
  int unsigned rises;
  int          n_errors = 0;
  int          n_checks = 0;
  count_src_t  src_tab[4] = '{SRC_DIV_ONE, SRC_DIV_EIGHT, SRC_DIV_THIRTY_TWO, SRC_RING_FAST};
  int          gap_tab[4] = '{0, 62, 62, 78};
  int          inc_tab[4] = '{2, 8, 2, 8};
  logic [7:0]  rst_adr[9] = '{OFF_CTRL_FIRST, OFF_CTRL_SECOND, OFF_WAVE_CTRL, OFF_COUNT, OFF_CMP_ZERO,
                              OFF_CMP_ONE, OFF_IRQ_STATUS, OFF_IRQ_ENABLE, OFF_PIN_FUNC};
  logic [31:0] rst_val[9] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_FFFF,
                              32'h0000_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  timer_output_compare u_timer_output_compare (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fast_ring_oscillator_clock(ring), .capture_input_pin(cap),
    .compare_waveform_output(wave), .capture_pin_gpio_in(gpio), .irq(irq));
  wave_sink u_wave_sink (.hclk(hclk), .hresetn(hresetn), .wave(wave), .rises(rises));

  always #2 hclk = ~hclk;

  // ring source: 40 ns period, phase unrelated to the bus clock
  initial begin
    ring = 1'b0;
    #1.3;
    forever #20 ring = ~ring;
  end

  // single word transfers; every wait ends on hready so no slave latency is assumed
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= wr; hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask : rd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // watchdog: the overflow test alone needs about 66k cycles, the whole run under 67k
  initial begin
    repeat (80000) @(posedge hclk);
    n_errors++;
    print_verdict();
  end

  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0000_0000; cap = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(rst_adr[i], v); chk(v, rst_val[i]);
    end
    rd(8'h28, v); chk(v, 32'h0000_0000);
    wr(OFF_COUNT, 32'h0000_1234); rd(OFF_COUNT, v); chk(v, 32'h0000_0000);
    // every count source: count delta over a fixed span between two reads
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTRL_FIRST, {29'h0, src_tab[i], 1'b1});
      rd(OFF_COUNT, v);
      repeat (gap_tab[i]) @(posedge hclk);
      rd(OFF_COUNT, w); chk(w - v, inc_tab[i]);
      wr(OFF_CTRL_FIRST, 32'h0000_0000);
      @(posedge hclk);
      rd(OFF_COUNT, v); chk(v, 32'h0000_0000);
    end
    // compare-one clear: toggle on match zero, low on match one, period of eight
    wr(OFF_CMP_ZERO, 32'h0000_0003); wr(OFF_CMP_ONE, 32'h0000_0007);
    wr(OFF_CTRL_SECOND, 32'h0000_0094); wr(OFF_WAVE_CTRL, 32'h0000_003F);
    wr(OFF_IRQ_ENABLE, 32'h0000_000F); wr(OFF_CTRL_FIRST, 32'h0000_0001);
    repeat (40) @(posedge hclk);
    rd(OFF_COUNT, v); chk({31'h0, v <= 32'h7}, 32'h1);
    rd(OFF_IRQ_STATUS, v); chk(v, 32'h0000_0003);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, rises > 2}, 32'h1);
    wr(OFF_IRQ_ENABLE, 32'h0000_0000); repeat (2) @(posedge hclk); chk({31'h0, irq}, 32'h0);
    wr(OFF_CTRL_FIRST, 32'h0000_0000); wr(OFF_IRQ_CLEAR, 32'h0000_000F);
    rd(OFF_IRQ_STATUS, v); chk(v, 32'h0000_0000);
    wr(OFF_WAVE_CTRL, 32'h0000_0000); repeat (3) @(posedge hclk); chk({26'h0, wave}, 32'h0);
    // free run: a compare write while counting waits for the overflow
    wr(OFF_CTRL_SECOND, 32'h0000_0000); wr(OFF_CMP_ZERO, 32'h0000_8000); wr(OFF_CMP_ONE, 32'h0000_8800);
    wr(OFF_IRQ_ENABLE, 32'h0000_0007); wr(OFF_CTRL_FIRST, 32'h0000_0001);
    repeat (16) @(posedge hclk);
    wr(OFF_CMP_ZERO, 32'h0000_0040); rd(OFF_CMP_ZERO, v); chk(v, 32'h0000_0040);
    repeat (100) @(posedge hclk);
    rd(OFF_IRQ_STATUS, v); chk(v, 32'h0000_0000);
    repeat (32'h9000) @(posedge hclk);
    wr(OFF_IRQ_CLEAR, 32'h0000_000F);
    repeat (32'h7100) @(posedge hclk);
    rd(OFF_IRQ_STATUS, v); chk(v, 32'h0000_0005);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_CTRL_FIRST, 32'h0000_0000); wr(OFF_IRQ_CLEAR, 32'h0000_000F);
    // match drives the level high, upper three outputs inverted; the level outlives the stop
    wr(OFF_CMP_ZERO, 32'h0000_0002); wr(OFF_CMP_ONE, 32'h0000_FFFF);
    wr(OFF_CTRL_SECOND, 32'h0000_0030); wr(OFF_WAVE_CTRL, 32'h0000_00BF);
    rd(OFF_WAVE_CTRL, v); chk(v, 32'h0000_00BF);
    wr(OFF_CTRL_FIRST, 32'h0000_0001); repeat (8) @(posedge hclk);
    wr(OFF_CTRL_FIRST, 32'h0000_0000); wr(OFF_IRQ_CLEAR, 32'h0000_000F);
    chk({26'h0, wave}, 32'h0000_0007);
    // capture pin: plain input, then external interrupt, never a capture
    cap <= 1'b1; repeat (6) @(posedge hclk); chk({31'h0, gpio}, 32'h1);
    rd(OFF_IRQ_STATUS, v); chk(v, 32'h0000_0000);
    cap <= 1'b0; wr(OFF_PIN_FUNC, 32'h0000_0001);
    repeat (4) @(posedge hclk);
    cap <= 1'b1; repeat (8) @(posedge hclk);
    rd(OFF_IRQ_STATUS, v); chk(v, 32'h0000_0008);
    print_verdict();
  end
endmodule : timer_output_compare_tb
